// ---- sensor_fifo_batch_control.sv ----
// batching, watermark and mode control in front of the sensor fifo
//
// Functional notes
// - stop flag limits depth to threshold
// - runtime compression needs feature enable too
// - marker flag batches rate-change entries
// - forced raw every 8/16/32 writes
// - nine-bit threshold, msb here, word units
// - watermark flag when level reaches threshold
// - gyro rate code selects gyro writes
// - accel rate code selects accel writes
// - timestamp decimation off, 1, 8, 32
// - timestamp follows faster sensor rate, decimated
// - temperature rate code off/1.6/12.5/52
// - code 000 bypass, reserved codes unused
// - mode 001 stops storing when full
// - mode 110 overwrites oldest when full
// - mode 011 continuous, trigger fall, stop
// - mode 100 bypass, trigger fall, continuous
// - mode 111 bypass, trigger fall, stop
// - low threshold byte in preceding register
`timescale 1ns/1ns
module sensor_fifo_batch_control (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// sensor side
	input  wire logic        base_tick,
	input  wire logic        trigger,
	input  wire logic        compression_feature_on,
	input  wire logic [47:0] gyro_data,
	input  wire logic [47:0] accel_data,
	input  wire logic [47:0] temp_data,
	input  wire logic [47:0] timestamp_data,
	// fifo drain
	output logic             drain_valid,
	input  wire logic        drain_ready,
	output logic      [55:0] drain_data,
	// status
	output logic             watermark_flag,
	output logic             depth_reached,
	output logic      [4:0]  fifo_level
);
	typedef struct packed {
		logic [7:0]                   threshold_low;
		logic [7:0]                   thr_compress;
		logic [7:0]                   batch_rate;
		logic [7:0]                   mode_ts_temp;
		sensor_fifo_pkg::phase_t      phase;
		logic                         trig_prev;
		logic [12:0]                  div_cnt;
		logic [4:0]                   ts_dec;
		logic [4:0]                   raw_cnt;
		logic [4:0]                   pend;
		logic [7:0]                   rdata;
		logic                         wm;
		logic                         at_limit;
	} ctl_state_t;

	ctl_state_t  state;
	ctl_state_t  next_state;
	logic [1:0]  rst_sync;
	logic        rst_n_int;

	sensor_fifo_if #(.W(sensor_fifo_pkg::WORD_W), .LW(sensor_fifo_pkg::LEVEL_W)) fif ();

	sensor_word_fifo #(
		.WIDTH (sensor_fifo_pkg::WORD_W),
		.DEPTH (sensor_fifo_pkg::FIFO_DEPTH)
	) u_store (
		.clk   (clk),
		.rst_n (rst_n_int),
		.f     (fif.store)
	);

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync[1];

	// shift for gyro/accel codes, 4'hF means not batched
	function automatic logic [3:0] sensor_shift(input logic [3:0] code, input logic [3:0] slow);
		if (code == 4'h0 || code > sensor_fifo_pkg::RATE_SLOW_CODE) begin
			sensor_shift = 4'hF;
		end else if (code == sensor_fifo_pkg::RATE_SLOW_CODE) begin
			sensor_shift = slow;
		end else begin
			sensor_shift = sensor_fifo_pkg::RATE_TOP_CODE - code;
		end
	endfunction

	// true on the ticks that fall on a 2^shift boundary
	function automatic logic rate_hit(input logic [12:0] cnt, input logic [3:0] shift);
		logic [12:0] mask;
		mask = (13'h0001 << shift) - 13'h0001;
		rate_hit = (shift != 4'hF) && ((cnt & mask) == 13'h0000);
	endfunction

	// phase entered when a mode code is written
	function automatic sensor_fifo_pkg::phase_t start_phase(input logic [2:0] code);
		case (code)
			sensor_fifo_pkg::MODE_STOP_FULL:    start_phase = sensor_fifo_pkg::PH_STOP;
			sensor_fifo_pkg::MODE_CONT_TO_STOP: start_phase = sensor_fifo_pkg::PH_CONT;
			sensor_fifo_pkg::MODE_CONTINUOUS:   start_phase = sensor_fifo_pkg::PH_CONT;
			default:                            start_phase = sensor_fifo_pkg::PH_BYPASS;
		endcase
	endfunction

	// stop bit limits depth only while the threshold is below the store size
	function automatic logic threshold_limits(input logic stop, input logic [8:0] thr);
		if (stop && thr < 9'(sensor_fifo_pkg::FIFO_DEPTH)) begin
			threshold_limits = 1'b1;
		end else begin
			threshold_limits = 1'b0;
		end
	endfunction

	logic [2:0]  mode_code;
	logic [3:0]  gyro_shift;
	logic [3:0]  accel_shift;
	logic [3:0]  temp_shift;
	logic [3:0]  fast_shift;
	logic [1:0]  ts_sel;
	logic [1:0]  temp_sel;
	logic [1:0]  raw_sel;
	logic [8:0]  threshold;
	logic [8:0]  limit;
	logic [8:0]  level9;
	logic        at_limit;
	logic        compress_on;
	logic        forced_raw;
	logic        ts_event;
	logic        ts_due;
	logic        trig_fall;
	logic [4:0]  new_events;
	logic [4:0]  pick;
	logic [4:0]  tag_id;
	logic [47:0] pick_data;
	logic        is_sensor;
	logic        commit;
	logic [4:0]  raw_mask;

	always_comb begin
		mode_code   = state.mode_ts_temp[sensor_fifo_pkg::MODE_LSB +: 3];
		gyro_shift  = sensor_shift(state.batch_rate[sensor_fifo_pkg::GYRO_RATE_LSB +: 4],
			sensor_fifo_pkg::GYRO_SLOW_SHIFT);
		accel_shift = sensor_shift(state.batch_rate[sensor_fifo_pkg::ACCEL_RATE_LSB +: 4],
			sensor_fifo_pkg::ACCEL_SLOW_SHIFT);
		temp_sel    = state.mode_ts_temp[sensor_fifo_pkg::TEMP_RATE_LSB +: 2];
		case (temp_sel)
			2'h1:    temp_shift = sensor_fifo_pkg::TEMP_SHIFT_1;
			2'h2:    temp_shift = sensor_fifo_pkg::TEMP_SHIFT_2;
			2'h3:    temp_shift = sensor_fifo_pkg::TEMP_SHIFT_3;
			default: temp_shift = 4'hF;
		endcase
		fast_shift  = (gyro_shift < accel_shift) ? gyro_shift : accel_shift;
		ts_sel      = state.mode_ts_temp[sensor_fifo_pkg::TS_DECIMATION_LSB +: 2];
		ts_event    = base_tick && rate_hit(state.div_cnt, fast_shift);
		case (ts_sel)
			2'h1:    ts_due = ts_event;
			2'h2:    ts_due = ts_event && (state.ts_dec[2:0] == 3'h7);
			2'h3:    ts_due = ts_event && (state.ts_dec == 5'h1F);
			default: ts_due = 1'b0;
		endcase
		threshold   = {state.thr_compress[sensor_fifo_pkg::THRESHOLD_MSB_BIT],
			state.threshold_low};
		limit       = threshold_limits(
			state.thr_compress[sensor_fifo_pkg::STOP_AT_THRESHOLD_BIT], threshold)
			? threshold : 9'(sensor_fifo_pkg::FIFO_DEPTH);
		level9      = {4'h0, fif.level};
		at_limit    = level9 >= limit;
		compress_on = state.thr_compress[sensor_fifo_pkg::COMPRESSION_RT_BIT]
			&& compression_feature_on;
		raw_sel     = state.thr_compress[sensor_fifo_pkg::FORCED_RAW_LSB +: 2];
		case (raw_sel)
			2'h1:    raw_mask = 5'h07;
			2'h2:    raw_mask = 5'h0F;
			2'h3:    raw_mask = 5'h1F;
			default: raw_mask = 5'h00;
		endcase
		forced_raw  = (raw_sel != 2'h0) && ((state.raw_cnt & raw_mask) == raw_mask);
		trig_fall   = state.trig_prev && !trigger;
		new_events  = 5'h00;
		if (base_tick) begin
			new_events[0] = rate_hit(state.div_cnt, gyro_shift);
			new_events[1] = rate_hit(state.div_cnt, accel_shift);
			new_events[2] = rate_hit(state.div_cnt, temp_shift);
		end
		new_events[3] = ts_due;
		if (reg_wr && reg_addr == sensor_fifo_pkg::ADDR_BATCH_RATE
			&& reg_wdata != state.batch_rate
			&& state.thr_compress[sensor_fifo_pkg::RATE_MARKER_BIT]) begin
			new_events[4] = 1'b1;
		end
	end

	// one entry per cycle, marker first, then gyro, accel, temp, timestamp
	always_comb begin
		pick      = 5'h00;
		tag_id    = 5'h00;
		pick_data = 48'h0;
		is_sensor = 1'b0;
		if (state.pend[4]) begin
			pick      = 5'h10;
			tag_id    = sensor_fifo_pkg::TAG_RATE_MARKER;
			pick_data = {40'h0, state.batch_rate};
		end else if (state.pend[0]) begin
			pick      = 5'h01;
			tag_id    = sensor_fifo_pkg::TAG_GYRO;
			pick_data = gyro_data;
			is_sensor = 1'b1;
		end else if (state.pend[1]) begin
			pick      = 5'h02;
			tag_id    = sensor_fifo_pkg::TAG_ACCEL;
			pick_data = accel_data;
			is_sensor = 1'b1;
		end else if (state.pend[2]) begin
			pick      = 5'h04;
			tag_id    = sensor_fifo_pkg::TAG_TEMP;
			pick_data = temp_data;
		end else if (state.pend[3]) begin
			pick      = 5'h08;
			tag_id    = sensor_fifo_pkg::TAG_TIMESTAMP;
			pick_data = timestamp_data;
		end
	end

	// fifo steering by phase
	always_comb begin
		fif.flush       = state.phase == sensor_fifo_pkg::PH_BYPASS;
		fif.drop_oldest = (state.phase == sensor_fifo_pkg::PH_CONT) && at_limit;
		fif.in_valid    = (pick != 5'h00) && (state.phase == sensor_fifo_pkg::PH_CONT
			|| (state.phase == sensor_fifo_pkg::PH_STOP && !at_limit));
		fif.in_data     = {tag_id, compress_on && is_sensor && !forced_raw, 2'b00, pick_data};
		fif.out_ready   = drain_ready;
		commit          = (fif.in_valid && fif.in_ready)
			|| (state.phase == sensor_fifo_pkg::PH_STOP && at_limit);
	end

	always_comb begin
		next_state           = state;
		next_state.trig_prev = trigger;
		next_state.wm        = (state.phase != sensor_fifo_pkg::PH_BYPASS)
			&& (level9 >= threshold);
		next_state.at_limit  = at_limit;
		if (base_tick) begin
			next_state.div_cnt = state.div_cnt + 13'h0001;
		end
		if (ts_event) begin
			next_state.ts_dec = state.ts_dec + 5'h01;
		end
		if (commit && is_sensor) begin
			next_state.raw_cnt = state.raw_cnt + 5'h01;
		end
		// new events win over the clear of the entry just taken
		if (state.phase == sensor_fifo_pkg::PH_BYPASS) begin
			next_state.pend = 5'h00;
		end else begin
			next_state.pend = (state.pend & ~(commit ? pick : 5'h00)) | new_events;
		end
		// trigger-driven phase changes
		if (trig_fall) begin
			case (mode_code)
				sensor_fifo_pkg::MODE_CONT_TO_STOP: begin
					if (state.phase == sensor_fifo_pkg::PH_CONT) begin
						next_state.phase = sensor_fifo_pkg::PH_STOP;
					end
				end
				sensor_fifo_pkg::MODE_BYPASS_TO_CONT: begin
					if (state.phase == sensor_fifo_pkg::PH_BYPASS) begin
						next_state.phase = sensor_fifo_pkg::PH_CONT;
					end
				end
				sensor_fifo_pkg::MODE_BYPASS_TO_STOP: begin
					if (state.phase == sensor_fifo_pkg::PH_BYPASS) begin
						next_state.phase = sensor_fifo_pkg::PH_STOP;
					end
				end
				default: begin
					next_state.phase = state.phase;
				end
			endcase
		end
		// register writes
		if (reg_wr) begin
			case (reg_addr)
				sensor_fifo_pkg::ADDR_THRESHOLD_LOW: begin
					next_state.threshold_low = reg_wdata;
				end
				sensor_fifo_pkg::ADDR_THR_COMPRESS: begin
					next_state.thr_compress = reg_wdata & sensor_fifo_pkg::MASK_THR_COMPRESS;
				end
				sensor_fifo_pkg::ADDR_BATCH_RATE: begin
					next_state.batch_rate = reg_wdata;
				end
				sensor_fifo_pkg::ADDR_MODE_TS_TEMP: begin
					next_state.mode_ts_temp = reg_wdata & sensor_fifo_pkg::MASK_MODE_TS_TEMP;
					next_state.phase = start_phase(reg_wdata[sensor_fifo_pkg::MODE_LSB +: 3]);
				end
				default: begin
					next_state.rdata = state.rdata;
				end
			endcase
		end
		// register reads
		if (reg_rd) begin
			case (reg_addr)
				sensor_fifo_pkg::ADDR_THRESHOLD_LOW: next_state.rdata = state.threshold_low;
				sensor_fifo_pkg::ADDR_THR_COMPRESS:  next_state.rdata = state.thr_compress;
				sensor_fifo_pkg::ADDR_BATCH_RATE:    next_state.rdata = state.batch_rate;
				sensor_fifo_pkg::ADDR_MODE_TS_TEMP:  next_state.rdata = state.mode_ts_temp;
				sensor_fifo_pkg::ADDR_LEVEL_STATUS:
					next_state.rdata = {state.wm, state.at_limit, 1'b0, fif.level};
				default:                             next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			state               <= '0;
			state.threshold_low <= sensor_fifo_pkg::RST_THRESHOLD_LOW;
			state.thr_compress  <= sensor_fifo_pkg::RST_THR_COMPRESS;
			state.batch_rate    <= sensor_fifo_pkg::RST_BATCH_RATE;
			state.mode_ts_temp  <= sensor_fifo_pkg::RST_MODE_TS_TEMP;
			state.phase         <= sensor_fifo_pkg::PH_BYPASS;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata      = state.rdata;
	assign drain_valid    = fif.out_valid;
	assign drain_data     = fif.out_data;
	assign watermark_flag = state.wm;
	assign depth_reached  = state.at_limit;
	assign fifo_level     = fif.level;
endmodule

// ---- sensor_fifo_checker_sva.sv ----
// port-level assertions for the sensor fifo batch control
`timescale 1ns/1ns
module sensor_fifo_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register port
	input wire logic [6:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// drain and status
	input wire logic        drain_valid,
	input wire logic        drain_ready,
	input wire logic [55:0] drain_data,
	input wire logic        watermark_flag,
	input wire logic        depth_reached,
	input wire logic [4:0]  fifo_level
);
	typedef struct packed {
		logic [8:0] thr;
		logic       stop;
		logic [2:0] mode;
		logic [1:0] q;
	} shadow_t;
	shadow_t s;
	shadow_t next_s;
	logic    quiet;

	// shadow of the configuration, plus cycles since the last write
	always_comb begin
		next_s = s;
		next_s.q = reg_wr ? 2'h0 : (s.q == 2'h3 ? s.q : s.q + 2'h1);
		if (reg_wr && reg_addr == sensor_fifo_pkg::ADDR_THRESHOLD_LOW) begin
			next_s.thr[7:0] = reg_wdata;
		end
		if (reg_wr && reg_addr == sensor_fifo_pkg::ADDR_THR_COMPRESS) begin
			next_s.thr[8] = reg_wdata[0];
			next_s.stop = reg_wdata[7];
		end
		if (reg_wr && reg_addr == sensor_fifo_pkg::ADDR_MODE_TS_TEMP) begin
			next_s.mode = reg_wdata[2:0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign quiet = s.q == 2'h3 && !reg_wr;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence bypass_wr;
		reg_wr && reg_addr == sensor_fifo_pkg::ADDR_MODE_TS_TEMP && reg_wdata[2:0] == 3'h0;
	endsequence
	sequence full_idle;
		quiet && fifo_level == 5'h10 && !(drain_valid && drain_ready);
	endsequence

	level_max_a: assert property (fifo_level <= 5'h10 && drain_valid == (fifo_level != 5'h00))
		else $error("fifo level out of range");
	wm_level_a: assert property (quiet && $stable(fifo_level) && s.thr != 9'h000 |->
		watermark_flag == ({4'h0, fifo_level} >= s.thr)) else $error("watermark flag wrong");
	depth_limit_a: assert property (quiet && $stable(fifo_level) && s.thr != 9'h000 |->
		depth_reached == ({4'h0, fifo_level} >= (s.stop && s.thr < 9'h010 ? s.thr : 9'h010)))
		else $error("depth flag wrong");
	bypass_flush_a: assert property (bypass_wr |-> ##[1:4] fifo_level == 5'h00 && !watermark_flag)
		else $error("bypass did not empty the fifo");
	stop_full_a: assert property (full_idle and s.mode == 3'h1 && !s.stop |=>
		fifo_level == 5'h10 && $stable(drain_data)) else $error("full fifo changed in stop mode");
	cont_full_a: assert property (full_idle and s.mode == 3'h6 |=> fifo_level == 5'h10)
		else $error("continuous fifo left full level");
	status_rd_a: assert property (reg_rd && reg_addr == sensor_fifo_pkg::ADDR_LEVEL_STATUS |=>
		reg_rdata == {$past(watermark_flag), $past(depth_reached), 1'b0, $past(fifo_level)})
		else $error("status read wrong");
	reserved_bits_a: assert property (reg_rd && reg_addr == sensor_fifo_pkg::ADDR_THR_COMPRESS |=>
		(reg_rdata & ~sensor_fifo_pkg::MASK_THR_COMPRESS) == 8'h00) else $error("reserved bit set");
	thr_read_a: assert property (reg_rd && reg_addr == sensor_fifo_pkg::ADDR_THRESHOLD_LOW |=>
		reg_rdata == s.thr[7:0]) else $error("threshold low readback wrong");
endmodule

bind sensor_fifo_batch_control sensor_fifo_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rd, .reg_rdata, .drain_valid, .drain_ready, .drain_data, .watermark_flag,
	.depth_reached, .fifo_level);

// ---- sensor_fifo_if.sv ----
// carrier between the batch controller and its storage fifo
`timescale 1ns/1ns
interface sensor_fifo_if #(parameter int W = 56, parameter int LW = 5);
	logic          in_valid;
	logic          in_ready;
	logic [W-1:0]  in_data;
	logic          out_valid;
	logic          out_ready;
	logic [W-1:0]  out_data;
	logic          flush;
	logic          drop_oldest;
	logic [LW-1:0] level;

	modport producer (
		output in_valid, in_data, out_ready, flush, drop_oldest,
		input  in_ready, out_valid, out_data, level
	);
	modport store (
		input  in_valid, in_data, out_ready, flush, drop_oldest,
		output in_ready, out_valid, out_data, level
	);
endinterface

// ---- sensor_fifo_pkg.sv ----
// constants and types shared by the sensor fifo batch control design
package sensor_fifo_pkg;

	// register offsets
	localparam logic [6:0] ADDR_THRESHOLD_LOW  = 7'h07;
	localparam logic [6:0] ADDR_THR_COMPRESS   = 7'h08;
	localparam logic [6:0] ADDR_BATCH_RATE     = 7'h09;
	localparam logic [6:0] ADDR_MODE_TS_TEMP   = 7'h0A;
	localparam logic [6:0] ADDR_LEVEL_STATUS   = 7'h10;

	// reset values
	localparam logic [7:0] RST_THRESHOLD_LOW   = 8'h00;
	localparam logic [7:0] RST_THR_COMPRESS    = 8'h00;
	localparam logic [7:0] RST_BATCH_RATE      = 8'h00;
	localparam logic [7:0] RST_MODE_TS_TEMP    = 8'h00;

	// writable bit masks, reserved bits read zero
	localparam logic [7:0] MASK_THR_COMPRESS   = 8'hD7;
	localparam logic [7:0] MASK_MODE_TS_TEMP   = 8'hF7;

	// field positions
	localparam int STOP_AT_THRESHOLD_BIT = 7;
	localparam int COMPRESSION_RT_BIT    = 6;
	localparam int RATE_MARKER_BIT       = 4;
	localparam int FORCED_RAW_LSB        = 1;
	localparam int THRESHOLD_MSB_BIT     = 0;
	localparam int GYRO_RATE_LSB         = 4;
	localparam int ACCEL_RATE_LSB        = 0;
	localparam int TS_DECIMATION_LSB     = 6;
	localparam int TEMP_RATE_LSB         = 4;
	localparam int MODE_LSB              = 0;

	// operating mode codes
	localparam logic [2:0] MODE_BYPASS         = 3'h0;
	localparam logic [2:0] MODE_STOP_FULL      = 3'h1;
	localparam logic [2:0] MODE_CONT_TO_STOP   = 3'h3;
	localparam logic [2:0] MODE_BYPASS_TO_CONT = 3'h4;
	localparam logic [2:0] MODE_CONTINUOUS     = 3'h6;
	localparam logic [2:0] MODE_BYPASS_TO_STOP = 3'h7;

	// rate ladder, as a power-of-two division of the base tick
	localparam logic [3:0] RATE_TOP_CODE       = 4'hA;
	localparam logic [3:0] RATE_SLOW_CODE      = 4'hB;
	localparam logic [3:0] GYRO_SLOW_SHIFT     = 4'hA;
	localparam logic [3:0] ACCEL_SLOW_SHIFT    = 4'hC;
	localparam logic [3:0] TEMP_SHIFT_1        = 4'hC;
	localparam logic [3:0] TEMP_SHIFT_2        = 4'h9;
	localparam logic [3:0] TEMP_SHIFT_3        = 4'h7;

	// entry tags (source id)
	localparam logic [4:0] TAG_GYRO            = 5'h01;
	localparam logic [4:0] TAG_ACCEL           = 5'h02;
	localparam logic [4:0] TAG_TEMP            = 5'h03;
	localparam logic [4:0] TAG_TIMESTAMP       = 5'h04;
	localparam logic [4:0] TAG_RATE_MARKER     = 5'h13;

	// storage geometry: six data bytes plus one tag byte per word
	localparam int FIFO_DEPTH = 16;
	localparam int DATA_W     = 48;
	localparam int WORD_W     = 56;
	localparam int LEVEL_W    = 5;

	typedef enum logic [2:0] {
		PH_BYPASS = 3'b001,
		PH_STOP   = 3'b010,
		PH_CONT   = 3'b100
	} phase_t;

endpackage

// ---- sensor_host_model.sv ----
// host model: register writes and reads, drain consumer
`timescale 1ns/1ns
module sensor_host_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [6:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	// drain
	output logic            drain_ready
);
	initial begin
		reg_addr = 7'h7F;
		reg_wr = 1'h0;
		reg_wdata = 8'hFF;
		reg_rd = 1'h0;
		drain_ready = 1'h0;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == sensor_fifo_pkg::ADDR_MODE_TS_TEMP && (v[2:0] == 3'h2 || v[2:0] == 3'h5)) begin
			v[2:0] = 3'h0;
		end
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'h1;
		@(posedge clk);
		#1 reg_wr = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_rd = 1'h1;
		@(posedge clk);
		#1 reg_rd = 1'h0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
	// stall for w cycles, then take one word
	task automatic pop(input int w);
		repeat (w) @(posedge clk);
		@(posedge clk);
		#1 drain_ready = 1'h1;
		@(posedge clk);
		#1 drain_ready = 1'h0;
	endtask
endmodule

// ---- sensor_word_fifo.sv ----
// word fifo with flush and drop-oldest on push
`timescale 1ns/1ns
module sensor_word_fifo #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic    clk,
	input wire logic    rst_n,
	// fifo ports
	sensor_fifo_if.store f
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] rd_ptr;
		logic [PW-1:0] wr_ptr;
		logic [PW:0]   count;
	} fifo_state_t;

	fifo_state_t   state;
	fifo_state_t   next_state;
	logic [WIDTH-1:0] mem [DEPTH];
	logic          push;
	logic          pop;
	logic          full;

	assign full        = state.count == (PW+1)'(DEPTH);
	assign f.in_ready  = !full || f.drop_oldest;
	assign f.out_valid = state.count != '0;
	assign f.out_data  = mem[state.rd_ptr];
	assign f.level     = state.count;
	assign push        = f.in_valid && f.in_ready && !f.flush;
	assign pop         = f.out_valid && (f.out_ready || (f.drop_oldest && push));

	always_comb begin
		next_state = state;
		if (f.flush) begin
			next_state = '0;
		end else begin
			if (push) begin
				next_state.wr_ptr = state.wr_ptr + 1'b1;
			end
			if (pop) begin
				next_state.rd_ptr = state.rd_ptr + 1'b1;
			end
			next_state.count = state.count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[state.wr_ptr] <= f.in_data;
		end
	end
endmodule

// ---- tb_sensor_fifo_batch_control.sv ----
// self-checking bench for the sensor fifo batch control
`timescale 1ns/1ns
module tb_sensor_fifo_batch_control;
	typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	localparam int LIMIT = 20000;
	logic        clk;
	logic        rst_n;
	logic [6:0]  reg_addr;
	logic        reg_wr;
	logic [7:0]  reg_wdata;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        base_tick;
	logic        trigger;
	logic        feat;
	logic [47:0] smp;
	logic [47:0] s0;
	logic        drain_valid;
	logic        drain_ready;
	logic [55:0] drain_data;
	logic        watermark_flag;
	logic        depth_reached;
	logic [4:0]  fifo_level;
	logic [7:0]  rv;
	int          err_count;
	int          compares;
	int          cyc;
	int          k;
	int          n;
	row_t        rows [6];

	sensor_fifo_batch_control DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.base_tick(base_tick), .trigger(trigger), .compression_feature_on(feat),
		.gyro_data(smp), .accel_data(~smp), .temp_data({smp[23:0], smp[47:24]}),
		.timestamp_data(smp + 48'h1), .drain_valid(drain_valid), .drain_ready(drain_ready),
		.drain_data(drain_data), .watermark_flag(watermark_flag),
		.depth_reached(depth_reached), .fifo_level(fifo_level));
	sensor_host_model H (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.drain_ready(drain_ready));

	task automatic chk(input string nm, input logic [55:0] got, input logic [55:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int t);
		repeat (t) begin
			@(posedge clk);
			#1 base_tick = 1'h1;
			smp = smp + 48'h1;
			@(posedge clk);
			#1 base_tick = 1'h0;
			repeat (4) @(posedge clk);
			#1;
		end
	endtask
	// bypass first, so each case starts from an empty fifo
	task automatic cfg(input logic [7:0] c8, input logic [7:0] c9, input logic [7:0] ca);
		H.wr(sensor_fifo_pkg::ADDR_MODE_TS_TEMP, 8'h00);
		H.wr(sensor_fifo_pkg::ADDR_THR_COMPRESS, c8);
		H.wr(sensor_fifo_pkg::ADDR_BATCH_RATE, c9);
		chk("flush", {watermark_flag, fifo_level}, 56'h0);
		H.wr(sensor_fifo_pkg::ADDR_MODE_TS_TEMP, ca);
		s0 = smp + 48'h1;
	endtask

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			results();
		end
	end

	initial begin
		rst_n = 1'h0;
		base_tick = 1'h0;
		trigger = 1'h0;
		feat = 1'h0;
		smp = 48'h0;
		err_count = 0;
		compares = 0;
		cyc = 0;
		rows = '{'{sensor_fifo_pkg::ADDR_THRESHOLD_LOW, 8'hFF, 8'hFF},
			'{sensor_fifo_pkg::ADDR_THR_COMPRESS, 8'hFF, 8'hD7},
			'{sensor_fifo_pkg::ADDR_BATCH_RATE, 8'hBA, 8'hBA},
			'{sensor_fifo_pkg::ADDR_MODE_TS_TEMP, 8'hFF, 8'hF7},
			'{7'h20, 8'h55, 8'h00},
			'{sensor_fifo_pkg::ADDR_THRESHOLD_LOW, 8'h05, 8'h05}};
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			H.wr(rows[i].a, rows[i].d);
			H.rd(rows[i].a, rv);
			chk("register", rv, rows[i].e);
		end
		// stop when full, then continuous overwrite
		cfg(8'h00, 8'hA0, sensor_fifo_pkg::MODE_STOP_FULL);
		tick(20);
		H.rd(sensor_fifo_pkg::ADDR_LEVEL_STATUS, rv);
		chk("status", rv, 8'hD0);
		chk("stop head", drain_data, {sensor_fifo_pkg::TAG_GYRO, 3'h0, s0});
		cfg(8'h00, 8'hA0, sensor_fifo_pkg::MODE_CONTINUOUS);
		tick(20);
		chk("cont head", drain_data, {sensor_fifo_pkg::TAG_GYRO, 3'h0, s0 + 48'h4});
		// depth limited to threshold 5, then threshold 0x105
		cfg(8'h80, 8'hA0, sensor_fifo_pkg::MODE_STOP_FULL);
		tick(8);
		chk("limit", {depth_reached, fifo_level}, 56'h25);
		cfg(8'h01, 8'hA0, sensor_fifo_pkg::MODE_CONTINUOUS);
		tick(20);
		chk("ninth bit", {watermark_flag, fifo_level}, 56'h10);
		// trigger-driven modes
		for (k = 0; k < 2; k++) begin
			trigger = 1'h1;
			cfg(8'h00, 8'hA0, k == 1 ? 8'h07 : 8'h04);
			tick(3);
			chk("before fall", fifo_level, 56'h0);
			trigger = 1'h0;
			s0 = smp + 48'h1;
			tick(20);
			chk("after fall", drain_data[47:0], k == 1 ? s0 : s0 + 48'h4);
		end
		trigger = 1'h1;
		cfg(8'h00, 8'hA0, sensor_fifo_pkg::MODE_CONT_TO_STOP);
		tick(20);
		trigger = 1'h0;
		tick(3);
		chk("cont to stop", drain_data[47:0], s0 + 48'h4);
		// rate-change marker ahead of sensor data
		cfg(8'h10, 8'hA0, sensor_fifo_pkg::MODE_STOP_FULL);
		H.wr(sensor_fifo_pkg::ADDR_BATCH_RATE, 8'hA1);
		tick(1);
		chk("marker", drain_data[55:51], sensor_fifo_pkg::TAG_RATE_MARKER);
		// gyro, accel and undecimated timestamp from one tick
		cfg(8'h00, 8'hAA, 8'h41);
		tick(1);
		chk("ts level", fifo_level, 56'h3);
		chk("gyro", drain_data[55:51], sensor_fifo_pkg::TAG_GYRO);
		H.pop(1);
		chk("accel", drain_data, {sensor_fifo_pkg::TAG_ACCEL, 3'h0, ~smp});
		H.pop(0);
		chk("ts", drain_data[55:51], sensor_fifo_pkg::TAG_TIMESTAMP);
		H.pop(2);
		chk("empty", drain_valid, 56'h0);
		// compression: feature input gates the runtime bit
		cfg(8'h40, 8'hA0, sensor_fifo_pkg::MODE_STOP_FULL);
		tick(1);
		chk("feature off", drain_data[50], 56'h0);
		feat = 1'h1;
		for (k = 0; k < 4; k++) begin
			cfg(8'h40 | (k << 1), 8'hA0, sensor_fifo_pkg::MODE_STOP_FULL);
			n = 0;
			repeat (k == 0 ? 8 : 4 << k) begin
				tick(1);
				n += (drain_data[50] === 1'h0);
				H.pop(k);
			end
			chk("raw words", n, k == 0 ? 56'h0 : 56'h1);
		end
		tick(2);
		// reset in mid-run returns the defaults
		rst_n = 1'h0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (3) @(posedge clk);
		for (k = 0; k < 4; k++) begin
			H.rd(sensor_fifo_pkg::ADDR_THRESHOLD_LOW + 7'(k), rv);
			chk("reset value", rv, sensor_fifo_pkg::RST_BATCH_RATE);
		end
		chk("reset level", {drain_valid, fifo_level}, 56'h0);
		// temperature code 3: only the first tick after reset hits its rate
		cfg(8'h00, 8'h00, 8'h31);
		tick(3);
		chk("temp", {fifo_level, drain_data[55:51]}, {5'h01, sensor_fifo_pkg::TAG_TEMP});
		results();
	end
endmodule
